/* rtl/dacoc_pkg.sv */
// shared constants and types for both ends of the dac output control link
package dacoc_pkg;
   // channel count and field widths
   localparam int NUM_CHAN = 4;
   localparam int CODE_W   = 14;   // signed level code in output steps
   localparam int VAL_W    = 26;   // signed command value
   localparam int DATA_W   = 24;   // answer word
   localparam int LOC_W    = 4;    // slot location field
   // link commands
   typedef enum logic [2:0] {
      set_voltage_level_cmd   = 3'h0,
      set_current_level_cmd   = 3'h1,
      set_percent_level_cmd   = 3'h2,
      identity_query_cmd      = 3'h3,
      card_reset_cmd          = 3'h4,
      slot_location_write_cmd = 3'h5,
      slot_location_read_cmd  = 3'h6,
      wait_program_cmd        = 3'h7
   } dacoc_op_t;
   // clock and settle tick timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_TIME_NS  = 819_200;
   localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // quantisation: volts in uV, amps in nA, both steps are 2500 units
   localparam int STEP_FINE     = 2500;
   localparam int HALF_STEP     = 1250;
   localparam int VOLT_MAX_UV   = 10_235_000;
   localparam int CURR_MAX_NA   = 20_167_500;
   localparam int CURR_MIN_NA   = 4_000_000;
   // percent value in 0.0001 percent units, scaled to uV or nA
   localparam int PERC_V_SCALE  = 10;
   localparam int PERC_I_SCALE  = 20;
   localparam int PERC_I4_SCALE = 16;
   // settle wait programming
   localparam logic [LOC_W-1:0] WAIT_ARM_LOC   = 4'h2;
   localparam logic [7:0]       WAIT_ARM_KEY   = 8'h0d;
   localparam logic [LOC_W-1:0] WAIT_BYTES_LOC = 4'h6;
   localparam logic [7:0]       WAIT_LO_RST    = 8'h5b;
   localparam logic [7:0]       WAIT_HI_RST    = 8'h00;
   // identity code, value is arbitrary
   localparam logic [DATA_W-1:0] IDENT_CODE    = 24'h5a_0c3e;
endpackage

/* rtl/dacoc_if.sv */
// link between the mainframe end and the dac card end
`timescale 1ns/10ps
interface dacoc_if;
   import dacoc_pkg::*;
   logic                     cmd_valid;   // command offered
   logic                     cmd_ready;   // card can take a command
   dacoc_op_t                cmd_op;      // command code
   logic [1:0]               cmd_chan;    // channel number
   logic [LOC_W-1:0]         cmd_loc;     // slot location
   logic signed [VAL_W-1:0]  cmd_value;   // level value or byte
   logic                     rsp_valid;   // answer pulse
   logic                     rsp_err;     // command refused
   logic [DATA_W-1:0]        rsp_data;    // answer word
   logic                     settle_busy; // host must keep waiting
   // mainframe end
   modport host (output cmd_valid, cmd_op, cmd_chan, cmd_loc, cmd_value,
                 input cmd_ready, rsp_valid, rsp_err, rsp_data, settle_busy);
   // card end
   modport card (input cmd_valid, cmd_op, cmd_chan, cmd_loc, cmd_value,
                 output cmd_ready, rsp_valid, rsp_err, rsp_data, settle_busy);
endinterface

/* rtl/dacoc_card.sv */
// dac card end: channel state, level quantisation and settle wait
`timescale 1ns/10ps
//
// Contract
// - channels open after power-on or reset command
// - programmed channel stays connected until reset
// - four channels, each voltage or current mode
// - host waits settle period after programming
// - card holds readable, reprogrammable settle count
// - arm with 13 at 2, bytes at 6
// - low byte 1..255 default 91, high 0
// - voltage unipolar or bipolar, 2.5 mV steps
// - voltage rounded to nearest step
// - voltage command range, negative only bipolar
// - voltage percent is ten times volts
// - current command range per current range
// - current percent formulas per current range
// - identity query returns fixed code
// - reset command restores power-on condition
// - current rounded to nearest 2.5 uA step
module dacoc_card #(
   parameter int TICK_LEN = dacoc_pkg::TICK_CYCLES  // cycles per settle tick
) (
   // clock and reset
   input  wire logic                            sys_clk,
   input  wire logic                            rst,
   // link to mainframe
   dacoc_if.card                                lnk,
   // channel configuration switches
   input  wire logic [dacoc_pkg::NUM_CHAN-1:0]  chan_is_current,
   input  wire logic [dacoc_pkg::NUM_CHAN-1:0]  chan_range_sel,
   // channel outputs
   output logic [dacoc_pkg::NUM_CHAN-1:0]       chan_connected,
   output logic signed [dacoc_pkg::CODE_W-1:0]  chan_level [dacoc_pkg::NUM_CHAN]
);
   import dacoc_pkg::*;

   // one-hot card states
   typedef enum logic [1:0] {
      st_idle   = 2'b01,
      st_settle = 2'b10
   } dacoc_card_st_t;

   dacoc_card_st_t     state;          // current state
   logic [7:0]         wait_lo;        // wait_count_low_byte
   logic [7:0]         wait_hi;        // wait_count_high_byte
   logic [7:0]         pend_lo;        // low byte held until high byte
   logic               wait_armed;     // location 2 key seen
   logic               wait_phase;     // next byte is high byte
   logic [15:0]        settle_cnt;     // remaining ticks
   logic [31:0]        tick_cnt;       // cycles within a tick
   logic               take;           // command taken this cycle
   logic               cmd_lvl;        // command is a level setting
   logic               card_clear;     // power-on or reset command
   int                 phys;           // requested level in uV or nA
   logic               lvl_ok;         // level in range for channel
   logic               is_cur;         // addressed channel mode
   logic               rng;            // addressed channel range

   // round a fine value to whole output steps, away from zero on ties
   function automatic logic signed [CODE_W-1:0] quant(input int x);
      int mag;
      mag = (x < 0) ? -x : x;
      mag = (mag + HALF_STEP) / STEP_FINE;
      quant = (x < 0) ? CODE_W'(-mag) : CODE_W'(mag);
   endfunction

   // command decode
   assign take       = lnk.cmd_valid && lnk.cmd_ready;
   assign cmd_lvl    = (lnk.cmd_op == set_voltage_level_cmd) ||
                       (lnk.cmd_op == set_current_level_cmd) ||
                       (lnk.cmd_op == set_percent_level_cmd);
   assign card_clear = rst || (take && lnk.cmd_op == card_reset_cmd);
   assign is_cur     = chan_is_current[lnk.cmd_chan];
   assign rng        = chan_range_sel[lnk.cmd_chan];

   // convert command value to a physical level and check its range
   always_comb begin
      phys   = int'(lnk.cmd_value);
      lvl_ok = 1'b0;
      case (lnk.cmd_op)
         set_voltage_level_cmd: begin
            lvl_ok = !is_cur && phys <= VOLT_MAX_UV &&
                     phys >= (rng ? -VOLT_MAX_UV : 0);
         end
         set_current_level_cmd: begin
            lvl_ok = is_cur && phys <= CURR_MAX_NA &&
                     phys >= (rng ? CURR_MIN_NA : 0);
         end
         set_percent_level_cmd: begin
            if (!is_cur) begin
               phys   = int'(lnk.cmd_value) * PERC_V_SCALE;
               lvl_ok = phys <= VOLT_MAX_UV && phys >= (rng ? -VOLT_MAX_UV : 0);
            end else if (rng) begin
               phys   = CURR_MIN_NA + int'(lnk.cmd_value) * PERC_I4_SCALE;
               lvl_ok = lnk.cmd_value >= 0 && phys <= CURR_MAX_NA;
            end else begin
               phys   = int'(lnk.cmd_value) * PERC_I_SCALE;
               lvl_ok = lnk.cmd_value >= 0 && phys <= CURR_MAX_NA;
            end
         end
         default: begin
            lvl_ok = 1'b0;
         end
      endcase
   end

   // channel connection and level state
   always_ff @(posedge sys_clk) begin
      if (card_clear) begin
         chan_connected <= '0;
         for (int i = 0; i < NUM_CHAN; i++) begin
            chan_level[i] <= '0;
         end
      end else if (take && cmd_lvl && lvl_ok) begin
         chan_connected[lnk.cmd_chan] <= 1'b1;
         chan_level[lnk.cmd_chan]     <= quant(phys);
      end
   end

   // settle count programming through slot writes
   always_ff @(posedge sys_clk) begin
      if (card_clear) begin
         wait_lo    <= WAIT_LO_RST;
         wait_hi    <= WAIT_HI_RST;
         pend_lo    <= WAIT_LO_RST;
         wait_armed <= 1'b0;
         wait_phase <= 1'b0;
      end else if (take && lnk.cmd_op == slot_location_write_cmd) begin
         if (lnk.cmd_loc == WAIT_ARM_LOC) begin
            // key at location 2 arms the byte pair
            wait_armed <= (lnk.cmd_value[7:0] == WAIT_ARM_KEY);
            wait_phase <= 1'b0;
         end else if (lnk.cmd_loc == WAIT_BYTES_LOC && wait_armed) begin
            if (!wait_phase) begin
               if (lnk.cmd_value[7:0] != 8'h00) begin
                  pend_lo    <= lnk.cmd_value[7:0];
                  wait_phase <= 1'b1;
               end
            end else begin
               wait_lo    <= pend_lo;
               wait_hi    <= lnk.cmd_value[7:0];
               wait_armed <= 1'b0;
               wait_phase <= 1'b0;
            end
         end
      end
   end

   // settle state machine and tick counting
   always_ff @(posedge sys_clk) begin
      if (card_clear) begin
         state           <= st_idle;
         lnk.cmd_ready   <= 1'b1;
         lnk.settle_busy <= 1'b0;
         settle_cnt      <= '0;
         tick_cnt        <= '0;
      end else begin
         case (state)
            st_idle: begin
               if (take && cmd_lvl && lvl_ok) begin
                  settle_cnt      <= {wait_hi, wait_lo};
                  tick_cnt        <= '0;
                  lnk.cmd_ready   <= 1'b0;
                  lnk.settle_busy <= 1'b1;
                  state           <= st_settle;
               end
            end
            st_settle: begin
               if (tick_cnt == 32'(TICK_LEN - 1)) begin
                  // one count per tick, done at zero
                  tick_cnt <= '0;
                  if (settle_cnt <= 16'h0001) begin
                     settle_cnt      <= '0;
                     lnk.cmd_ready   <= 1'b1;
                     lnk.settle_busy <= 1'b0;
                     state           <= st_idle;
                  end else begin
                     settle_cnt <= settle_cnt - 16'h0001;
                  end
               end else begin
                  tick_cnt <= tick_cnt + 32'h0000_0001;
               end
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // answers, one cycle after a taken command
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lnk.rsp_valid <= 1'b0;
         lnk.rsp_err   <= 1'b0;
         lnk.rsp_data  <= '0;
      end else begin
         lnk.rsp_valid <= take;
         lnk.rsp_err   <= 1'b0;
         lnk.rsp_data  <= '0;
         if (take) begin
            case (lnk.cmd_op)
               identity_query_cmd: begin
                  lnk.rsp_data <= IDENT_CODE;
               end
               slot_location_read_cmd: begin
                  if (lnk.cmd_loc == WAIT_BYTES_LOC) begin
                     lnk.rsp_data <= {8'h00, wait_hi, wait_lo};
                  end
               end
               slot_location_write_cmd: begin
                  // byte pair without key, or zero low byte, is refused
                  lnk.rsp_err <= lnk.cmd_loc == WAIT_BYTES_LOC &&
                                 (!wait_armed ||
                                  (!wait_phase && lnk.cmd_value[7:0] == 8'h00));
               end
               card_reset_cmd: begin
                  lnk.rsp_err <= 1'b0;
               end
               default: begin
                  // level commands out of range or wrong mode
                  lnk.rsp_err <= !(cmd_lvl && lvl_ok);
               end
            endcase
         end
      end
   end
endmodule

/* rtl/dacoc_host.sv */
// mainframe end: issues slot commands and honours the settle wait
`timescale 1ns/10ps
module dacoc_host (
   // clock and reset
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   // link to card
   dacoc_if.host                               lnk,
   // user command port
   input  wire logic                           usr_valid,
   output logic                                usr_ready,
   input  wire dacoc_pkg::dacoc_op_t           usr_op,
   input  wire logic [1:0]                     usr_chan,
   input  wire logic [dacoc_pkg::LOC_W-1:0]    usr_loc,
   input  wire logic signed [dacoc_pkg::VAL_W-1:0] usr_value,
   // user answer port
   output logic                                usr_done,
   output logic                                usr_err,
   output logic [dacoc_pkg::DATA_W-1:0]        usr_data
);
   import dacoc_pkg::*;

   // one-hot host states
   typedef enum logic [3:0] {
      h_idle   = 4'b0001,
      h_send   = 4'b0010,
      h_answer = 4'b0100,
      h_settle = 4'b1000
   } dacoc_host_st_t;

   dacoc_host_st_t     state;      // current state
   logic [1:0]         step;       // step within a wait program sequence
   logic               multi;      // sequence of three writes
   logic [7:0]         hold_lo;    // low byte for the sequence
   logic [7:0]         hold_hi;    // high byte for the sequence

   // host sequencing
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state         <= h_idle;
         usr_ready     <= 1'b1;
         usr_done      <= 1'b0;
         usr_err       <= 1'b0;
         usr_data      <= '0;
         step          <= 2'h0;
         multi         <= 1'b0;
         hold_lo       <= '0;
         hold_hi       <= '0;
         lnk.cmd_valid <= 1'b0;
         lnk.cmd_op    <= identity_query_cmd;
         lnk.cmd_chan  <= '0;
         lnk.cmd_loc   <= '0;
         lnk.cmd_value <= '0;
      end else begin
         usr_done <= 1'b0;
         case (state)
            h_idle: begin
               if (usr_valid) begin
                  usr_ready <= 1'b0;
                  usr_err   <= 1'b0;
                  usr_data  <= '0;
                  lnk.cmd_chan <= usr_chan;
                  if (usr_op == wait_program_cmd) begin
                     // low byte of zero never reaches the card
                     if (usr_value[7:0] == 8'h00) begin
                        usr_err   <= 1'b1;
                        usr_done  <= 1'b1;
                        usr_ready <= 1'b1;
                     end else begin
                        // key write to location 2 first
                        multi         <= 1'b1;
                        step          <= 2'h0;
                        hold_lo       <= usr_value[7:0];
                        hold_hi       <= usr_value[15:8];
                        lnk.cmd_op    <= slot_location_write_cmd;
                        lnk.cmd_loc   <= WAIT_ARM_LOC;
                        lnk.cmd_value <= VAL_W'(WAIT_ARM_KEY);
                        lnk.cmd_valid <= 1'b1;
                        state         <= h_send;
                     end
                  end else begin
                     multi         <= 1'b0;
                     lnk.cmd_op    <= usr_op;
                     lnk.cmd_loc   <= usr_loc;
                     lnk.cmd_value <= usr_value;
                     lnk.cmd_valid <= 1'b1;
                     state         <= h_send;
                  end
               end
            end
            h_send: begin
               // hold the command until the card takes it
               if (lnk.cmd_ready) begin
                  lnk.cmd_valid <= 1'b0;
                  state         <= h_answer;
               end
            end
            h_answer: begin
               if (lnk.rsp_valid) begin
                  usr_data <= lnk.rsp_data;
                  if (lnk.rsp_err) begin
                     usr_err   <= 1'b1;
                     usr_done  <= 1'b1;
                     usr_ready <= 1'b1;
                     state     <= h_idle;
                  end else if (multi && step != 2'h2) begin
                     // bytes to location 6, low then high
                     step          <= step + 2'h1;
                     lnk.cmd_loc   <= WAIT_BYTES_LOC;
                     lnk.cmd_value <= VAL_W'((step == 2'h0) ? hold_lo : hold_hi);
                     lnk.cmd_valid <= 1'b1;
                     state         <= h_send;
                  end else begin
                     state <= h_settle;
                  end
               end
            end
            h_settle: begin
               // no further action while the card settles
               if (!lnk.settle_busy) begin
                  usr_done  <= 1'b1;
                  usr_ready <= 1'b1;
                  state     <= h_idle;
               end
            end
            default: begin
               state <= h_idle;
            end
         endcase
      end
   end
endmodule

/* bench/dacoc_link_assertions.sv */
// protocol and timing checks on the dac output control link
`timescale 1ns/10ps
module dacoc_link_assertions (
   // clock and reset
   input wire logic                               sys_clk,
   input wire logic                               rst,
   // host to card
   input wire logic                               cmd_valid,
   input wire dacoc_pkg::dacoc_op_t               cmd_op,
   input wire logic [1:0]                         cmd_chan,
   input wire logic [dacoc_pkg::LOC_W-1:0]        cmd_loc,
   input wire logic signed [dacoc_pkg::VAL_W-1:0] cmd_value,
   // card to host
   input wire logic                               cmd_ready,
   input wire logic                               rsp_valid,
   input wire logic                               rsp_err,
   input wire logic [dacoc_pkg::DATA_W-1:0]       rsp_data,
   input wire logic                               settle_busy
);
   import dacoc_pkg::*;
   logic take;  // command accepted this edge
   assign take = cmd_valid && cmd_ready;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   rsp_after_take_a: assert property (take |=> rsp_valid)
      else $error("no answer one cycle after accept");
   rsp_has_cause_a: assert property (rsp_valid |-> $past(take))
      else $error("answer without accepted command");
   busy_blocks_a: assert property (settle_busy |-> !cmd_ready)
      else $error("ready raised during settle wait");
   settle_cause_a: assert property ($rose(settle_busy) |-> rsp_valid && !rsp_err
      && $past(cmd_op) inside {set_voltage_level_cmd, set_current_level_cmd,
      set_percent_level_cmd}) else $error("settle started without level command");
   settle_min_a: assert property ($rose(settle_busy) |-> settle_busy[*4])
      else $error("settle wait shorter than one tick");
   settle_end_a: assert property ($rose(settle_busy) |-> ##[4:1000] !settle_busy)
      else $error("settle wait never ends");
   ident_code_a: assert property (take && cmd_op == identity_query_cmd |=>
      !rsp_err && rsp_data == IDENT_CODE) else $error("wrong identity answer");
   volt_range_a: assert property (take && cmd_op == set_voltage_level_cmd &&
      (cmd_value > VOLT_MAX_UV || cmd_value < -VOLT_MAX_UV) |=> rsp_err && !settle_busy)
      else $error("voltage out of range accepted");
   curr_range_a: assert property (take && cmd_op == set_current_level_cmd &&
      (cmd_value < 0 || cmd_value > CURR_MAX_NA) |=> rsp_err)
      else $error("current out of range accepted");
   reset_cmd_a: assert property (take && cmd_op == card_reset_cmd |=>
      rsp_valid && !rsp_err && !settle_busy) else $error("reset command mishandled");
   other_read_a: assert property (take && cmd_op == slot_location_read_cmd &&
      cmd_loc != WAIT_BYTES_LOC |=> rsp_data == '0) else $error("odd location not zero");
   count_read_a: assert property (take && cmd_op == slot_location_read_cmd &&
      cmd_loc == WAIT_BYTES_LOC |=> rsp_data[23:16] == 8'h00 && rsp_data[7:0] != 8'h00)
      else $error("wait count read out of range");
   // main scenarios seen
   cover property (take && cmd_op == identity_query_cmd);
   cover property ($rose(settle_busy));
   cover property (rsp_valid && rsp_err);
   cover property (take && cmd_op == slot_location_write_cmd);
endmodule

/* bench/dac_channel_output_control_bench.sv */
// self-checking bench: host end and card end joined over the link
`timescale 1ns/10ps
module dac_channel_output_control_bench;
   import dacoc_pkg::*;
   localparam int TICK = 4;  // shortened settle tick
   typedef struct {
      logic       err;
      int         kind;   // 0 none, 1 data, 2 level
      int         dat;
      logic [1:0] ch;
      logic [3:0] conn;
   } dacoc_note_t;
   logic                     sys_clk = 1'b0;
   logic                     rst = 1'b1;
   logic                     usr_valid = 1'b0;
   logic                     usr_ready;
   dacoc_op_t                usr_op = identity_query_cmd;
   logic [1:0]               usr_chan = 2'h0;
   logic [LOC_W-1:0]         usr_loc = 4'h0;
   logic signed [VAL_W-1:0]  usr_value = '0;
   logic                     usr_done;
   logic                     usr_err;
   logic [DATA_W-1:0]        usr_data;
   logic [NUM_CHAN-1:0]      chan_is_current = 4'h3;  // ch0,ch1 current
   logic [NUM_CHAN-1:0]      chan_range_sel = 4'h6;   // ch1 4-20, ch2 bipolar
   logic [NUM_CHAN-1:0]      chan_connected;
   logic signed [CODE_W-1:0] chan_level [NUM_CHAN];
   dacoc_note_t              note_q [$];
   dacoc_note_t              cur;
   logic [3:0]               conn = 4'h0;         // expected connected mask
   int                       d_cnt = 91;
   int                       exp_settle = 0;
   int                       settle_len = 0;
   int                       err_count = 0;
   int                       num_checks = 0;
   logic [31:0]              rnd = 32'hcd89_c0af;
   int                       v;
   dacoc_if lnk_if ();
   dacoc_card #(.TICK_LEN(TICK)) dacoc_card_inst (.sys_clk(sys_clk), .rst(rst),
      .lnk(lnk_if), .chan_is_current(chan_is_current), .chan_range_sel(chan_range_sel),
      .chan_connected(chan_connected), .chan_level(chan_level));
   dacoc_host dacoc_host_inst (.sys_clk(sys_clk), .rst(rst), .lnk(lnk_if),
      .usr_valid(usr_valid), .usr_ready(usr_ready), .usr_op(usr_op), .usr_chan(usr_chan),
      .usr_loc(usr_loc), .usr_value(usr_value), .usr_done(usr_done), .usr_err(usr_err),
      .usr_data(usr_data));
   dacoc_link_assertions dacoc_link_assertions_inst (.sys_clk(sys_clk), .rst(rst),
      .cmd_valid(lnk_if.cmd_valid), .cmd_op(lnk_if.cmd_op), .cmd_chan(lnk_if.cmd_chan),
      .cmd_loc(lnk_if.cmd_loc), .cmd_value(lnk_if.cmd_value), .cmd_ready(lnk_if.cmd_ready),
      .rsp_valid(lnk_if.rsp_valid), .rsp_err(lnk_if.rsp_err), .rsp_data(lnk_if.rsp_data),
      .settle_busy(lnk_if.settle_busy));

   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic print_verdict();
      if (err_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // pseudo random step
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // nearest step, ties away from zero
   function automatic int q_step(input int x);
      return (x < 0) ? -((HALF_STEP - x) / STEP_FINE) : (x + HALF_STEP) / STEP_FINE;
   endfunction

   // one user request, expectation queued at accept
   task automatic issue(input dacoc_op_t op, input logic [1:0] ch, input logic [3:0] loc,
         input int val, input logic e_err, input int kind, input int e_dat);
      dacoc_note_t n;
      do @(posedge sys_clk); while (usr_ready !== 1'b1);
      usr_op <= op;
      usr_chan <= ch;
      usr_loc <= loc;
      usr_value <= 26'(val);
      usr_valid <= 1'b1;
      n.err = e_err;
      n.kind = kind;
      n.dat = e_dat;
      n.ch = ch;
      n.conn = conn;
      note_q.push_back(n);
      @(posedge sys_clk);
      usr_valid <= 1'b0;
   endtask

   // level command with expected step count
   task automatic lvl(input dacoc_op_t op, input logic [1:0] ch, input int val,
         input logic e_err, input int e_lvl);
      if (!e_err) begin
         conn[ch] = 1'b1;
         exp_settle = d_cnt * TICK;
      end
      issue(op, ch, 4'h0, val, e_err, e_err ? 0 : 2, e_lvl);
   endtask

   // answer watcher: oldest note against each done pulse
   always @(posedge sys_clk) begin
      if (!rst && usr_done === 1'b1) begin
         if (note_q.size() == 0) begin
            check(32'h0000_0001, 32'h0000_0000);
         end else begin
            cur = note_q.pop_front();
            check(32'(usr_err), 32'(cur.err));
            check(32'(chan_connected), 32'(cur.conn));
            if (cur.kind == 1) check(32'(usr_data), cur.dat);
            if (cur.kind == 2) begin
               check(32'(chan_level[cur.ch]), cur.dat);
               check(32'(lnk_if.settle_busy), 32'h0000_0000);
            end
         end
      end
   end

   // settle pulse length
   always @(posedge sys_clk) begin
      if (rst) begin
         settle_len = 0;
      end else if (lnk_if.settle_busy === 1'b1) begin
         settle_len++;
      end else if (settle_len != 0) begin
         check(settle_len, exp_settle);
         settle_len = 0;
      end
   end

   // hang guard
   initial begin
      repeat (30000) @(posedge sys_clk);
      err_count++;
      print_verdict();
   end

   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      issue(slot_location_read_cmd, 2'h0, 4'h6, 0, 1'b0, 1, 91);
      issue(identity_query_cmd, 2'h0, 4'h0, 0, 1'b0, 1, IDENT_CODE);
      issue(slot_location_read_cmd, 2'h0, 4'h3, 0, 1'b0, 1, 0);
      lvl(set_voltage_level_cmd, 2'h3, 6125000, 1'b0, 2450);
      lvl(set_voltage_level_cmd, 2'h3, 1250, 1'b0, 1);
      lvl(set_voltage_level_cmd, 2'h3, 1249, 1'b0, 0);
      lvl(set_voltage_level_cmd, 2'h3, -5000000, 1'b1, 0);
      lvl(set_voltage_level_cmd, 2'h3, 10235000, 1'b0, 4094);
      lvl(set_voltage_level_cmd, 2'h3, 10237600, 1'b1, 0);
      lvl(set_voltage_level_cmd, 2'h2, -1250, 1'b0, -1);
      lvl(set_voltage_level_cmd, 2'h2, -10235000, 1'b0, -4094);
      lvl(set_percent_level_cmd, 2'h2, 500250, 1'b0, 2001);
      lvl(set_percent_level_cmd, 2'h2, -317500, 1'b0, -1270);
      lvl(set_percent_level_cmd, 2'h2, 1023600, 1'b1, 0);
      lvl(set_voltage_level_cmd, 2'h0, 1000000, 1'b1, 0);
      lvl(set_current_level_cmd, 2'h2, 1000000, 1'b1, 0);
      lvl(set_current_level_cmd, 2'h0, 1250, 1'b0, 1);
      lvl(set_current_level_cmd, 2'h0, 20167500, 1'b0, 8067);
      lvl(set_current_level_cmd, 2'h0, -1, 1'b1, 0);
      lvl(set_current_level_cmd, 2'h1, 3000000, 1'b1, 0);
      lvl(set_current_level_cmd, 2'h1, 4000000, 1'b0, 1600);
      lvl(set_percent_level_cmd, 2'h0, 250000, 1'b0, 2000);
      lvl(set_percent_level_cmd, 2'h1, 625000, 1'b0, 5600);
      lvl(set_percent_level_cmd, 2'h1, 1010468, 1'b0, 8067);
      lvl(set_percent_level_cmd, 2'h0, 1008376, 1'b1, 0);
      chan_range_sel[3] <= 1'b1;
      lvl(set_voltage_level_cmd, 2'h3, -5000000, 1'b0, -2000);
      issue(wait_program_cmd, 2'h0, 4'h0, 32'h0000_0002, 1'b0, 0, 0);
      d_cnt = 2;
      issue(slot_location_read_cmd, 2'h0, 4'h6, 0, 1'b0, 1, 32'h0000_0002);
      lvl(set_voltage_level_cmd, 2'h3, 2500, 1'b0, 1);
      issue(wait_program_cmd, 2'h0, 4'h0, 32'h0000_0100, 1'b1, 0, 0);
      issue(slot_location_read_cmd, 2'h0, 4'h6, 0, 1'b0, 1, 32'h0000_0002);
      // random bipolar levels
      repeat (4) begin
         rnd = lfsr_next(rnd);
         v = int'(rnd % 32'd20470001) - VOLT_MAX_UV;
         lvl(set_voltage_level_cmd, 2'h2, v, 1'b0, q_step(v));
      end
      issue(wait_program_cmd, 2'h0, 4'h0, 32'h0000_0105, 1'b0, 0, 0);
      issue(slot_location_read_cmd, 2'h0, 4'h6, 0, 1'b0, 1, 32'h0000_0105);
      conn = 4'h0;
      d_cnt = 91;
      issue(card_reset_cmd, 2'h0, 4'h0, 0, 1'b0, 0, 0);
      issue(slot_location_read_cmd, 2'h0, 4'h6, 0, 1'b0, 1, 91);
      issue(slot_location_write_cmd, 2'h0, 4'h6, 7, 1'b1, 0, 0);
      lvl(set_voltage_level_cmd, 2'h1, 1000000, 1'b1, 0);
      lvl(set_voltage_level_cmd, 2'h3, 5000, 1'b0, 2);
      for (int i = 0; i < 2000 && note_q.size() != 0; i++) @(posedge sys_clk);
      if (note_q.size() != 0) err_count++;
      print_verdict();
   end
endmodule
